// ===== s5a_pkg.sv
// shared constants and types for the sinc5 averaging decimator
package s5a_pkg;
   // modulator sampling: one bit every four master clocks
   localparam int MOD_DIV = 4;
   localparam logic [1:0] PHASE_RESET = 2'h0;
   localparam logic [1:0] PHASE_LAST = 2'h3;
   // fixed fifth-order sinc stage
   localparam int SINC_ORDER = 5;
   localparam int SINC_DECIM = 64;
   localparam logic [5:0] DEC_RESET = 6'h00;
   localparam logic [5:0] DEC_LAST = 6'h3F;
   localparam logic [6:0] DEC_COUNT = 7'h40;
   localparam logic [8:0] SINC_PERIOD = 9'h100;
   localparam int SINC_W = 32;
   // averager widths: 12000 * 2^30 stays below 2^44
   localparam int CNT_W = 14;
   localparam int ACC_W = 46;
   localparam int RES_W = 32;
   localparam logic [5:0] DIV_STEPS = 6'h2E;
   localparam logic [5:0] STEP_ONE = 6'h01;
   // rate code table
   localparam int NUM_RATES = 16;
   localparam logic [7:0] RATE_CODE [NUM_RATES] = '{
      8'h03, 8'h13, 8'h23, 8'h33, 8'h43, 8'h53, 8'h63, 8'h72,
      8'h82, 8'h92, 8'hA1, 8'hB0, 8'hC0, 8'hD0, 8'hE0, 8'hF0};
   localparam logic [CNT_W-1:0] RATE_AVG [NUM_RATES] = '{
      14'h2EE0, 14'h1770, 14'h0BB8, 14'h07D0, 14'h04B0, 14'h03E8, 14'h0258, 14'h01F4,
      14'h012C, 14'h003C, 14'h001E, 14'h000F, 14'h0008, 14'h0004, 14'h0002, 14'h0001};
   localparam logic [CNT_W-1:0] AVG_RESET = 14'h0001;
   localparam logic [CNT_W-1:0] AVG_ONE = 14'h0001;
   localparam logic [CNT_W-1:0] CNT_RESET = 14'h0000;
   // result hand-off states, gray along idle -> divide -> emit
   typedef enum logic [1:0] {
      S5A_IDLE = 2'b00,
      S5A_DIVIDE = 2'b01,
      S5A_EMIT = 2'b11
   } s5a_state_e;
endpackage : s5a_pkg

// ===== s5a_sinc5.sv
// fixed fifth-order sinc decimator, ratio 64, on a one-bit stream
`timescale 1ns/1ps
`default_nettype none
module s5a_sinc5 (
   input wire logic i_core_clk, // master clock
   input wire logic i_arst_n, // async reset, active low
   input wire logic i_sample_stb, // one modulator sample this cycle
   input wire logic i_mod_bit, // modulator bit, 1 = +1, 0 = -1
   output logic [s5a_pkg::SINC_W-1:0] o_data, // signed stage output
   output logic o_valid // one-cycle pulse per output
);
   logic [s5a_pkg::SINC_W-1:0] integ [s5a_pkg::SINC_ORDER+1]; // integrator chain
   logic [s5a_pkg::SINC_W-1:0] comb [s5a_pkg::SINC_ORDER+1]; // comb chain
   logic [s5a_pkg::SINC_W-1:0] dly [s5a_pkg::SINC_ORDER+1]; // comb memories
   logic [5:0] dec_cnt; // input samples into this output
   logic dec_stb; // last sample of a decimation period
   logic [6:0] seen; // helper: samples between outputs

   // map the bit to +1 or -1; wrap-around arithmetic is exact at 32 bits
   assign integ[0] = {{(s5a_pkg::SINC_W-1){~i_mod_bit}}, 1'b1};
   assign comb[0] = integ[s5a_pkg::SINC_ORDER];
   assign dly[0] = '0;
   assign dec_stb = i_sample_stb && (dec_cnt == s5a_pkg::DEC_LAST);

   // integrators at input rate, combs at output rate
   for (genvar k = 1; k <= s5a_pkg::SINC_ORDER; k++) begin : g_stage
      always_ff @(posedge i_core_clk or negedge i_arst_n) begin
         if (!i_arst_n) begin
            integ[k] <= '0;
         end else if (i_sample_stb) begin
            integ[k] <= integ[k] + integ[k-1]; // R3
         end
      end
      always_ff @(posedge i_core_clk or negedge i_arst_n) begin
         if (!i_arst_n) begin
            dly[k] <= '0;
         end else if (dec_stb) begin
            dly[k] <= comb[k-1];
         end
      end
      assign comb[k] = comb[k-1] - dly[k];
   end

   // decimation counter
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         dec_cnt <= s5a_pkg::DEC_RESET;
      end else if (i_sample_stb) begin
         dec_cnt <= dec_cnt + 6'h01; // R3
      end
   end

   // output register; first few words are fill-up transient
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_data <= '0;
         o_valid <= 1'b0;
      end else begin
         o_valid <= dec_stb;
         if (dec_stb) begin
            o_data <= comb[s5a_pkg::SINC_ORDER];
         end
      end
   end

   // helper count of samples per output
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         seen <= 7'h00;
      end else if (o_valid) begin
         seen <= {6'h00, i_sample_stb};
      end else if (i_sample_stb) begin
         seen <= seen + 7'h01;
      end
   end

   // every word, the first after reset too, closes exactly 64 samples
   a_decim_ratio: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // R3
      o_valid |-> seen == s5a_pkg::DEC_COUNT)
      else $error("sinc stage output not after 64 samples");
endmodule : s5a_sinc5
`default_nettype wire

// ===== s5a_divider.sv
// sequential unsigned divider for the block average
`timescale 1ns/1ps
`default_nettype none
module s5a_divider (
   input wire logic i_core_clk, // master clock
   input wire logic i_arst_n, // async reset, active low
   input wire logic i_start, // pulse: take operands
   input wire logic [s5a_pkg::ACC_W-1:0] i_dividend, // block sum magnitude
   input wire logic [s5a_pkg::CNT_W-1:0] i_divisor, // average count
   output logic [s5a_pkg::ACC_W-1:0] o_quotient, // truncated quotient
   output logic o_done, // one-cycle pulse, quotient valid
   output logic o_busy // division in progress
);
   logic [s5a_pkg::CNT_W-1:0] rem; // partial remainder
   logic [s5a_pkg::CNT_W-1:0] dvs; // held divisor
   logic [5:0] step; // steps left
   logic [s5a_pkg::CNT_W:0] trial; // shifted remainder

   assign trial = {rem, o_quotient[s5a_pkg::ACC_W-1]};

   // one quotient bit per cycle; 46 cycles fits well inside 256
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rem <= '0;
         dvs <= s5a_pkg::AVG_ONE;
         step <= 6'h00;
         o_quotient <= '0;
         o_done <= 1'b0;
         o_busy <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_start && !o_busy) begin
            o_quotient <= i_dividend;
            dvs <= i_divisor;
            rem <= '0;
            step <= s5a_pkg::DIV_STEPS;
            o_busy <= 1'b1;
         end else if (o_busy) begin
            if (trial >= {1'b0, dvs}) begin
               rem <= s5a_pkg::CNT_W'(trial - {1'b0, dvs}); // R14
               o_quotient <= {o_quotient[s5a_pkg::ACC_W-2:0], 1'b1};
            end else begin
               rem <= trial[s5a_pkg::CNT_W-1:0];
               o_quotient <= {o_quotient[s5a_pkg::ACC_W-2:0], 1'b0};
            end
            step <= step - 6'h01;
            if (step == s5a_pkg::STEP_ONE) begin
               o_busy <= 1'b0;
               o_done <= 1'b1;
            end
         end
      end
   end

   a_div_latency: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // R14
      i_start && !o_busy |-> ##47 (o_done && !o_busy))
      else $error("divider done not 47 cycles after start");
endmodule : s5a_divider
`default_nettype wire

// ===== s5a_top.sv
// two-stage decimating filter: sinc5 by 64, then programmable averager
//
// Notes on behaviour
// R1: master clock comes from outside the filter
// R2: take one modulator bit every four clocks
// R3: sinc5 stage decimates 64, output per 256 clocks
// R4: rate code selects averager count
// R5: one result per completed averaging block
// R6: codes 03h..63h give 12000 down to 600
// R7: codes 72h,82h,92h,A1h give 500,300,60,30
// R8: B0h..E0h give 15,8,4,2; F0h bypasses
// R9: output rate follows master clock linearly
// R10: response is sinc5 times averager response
// R11: notches at output rate and its multiples
// R12: larger count narrows bandwidth, lowers rate
// R13: host picks 60 Hz multiple rates
// R14: sum exactly count outputs, divide, clear
// R15: unsupported code keeps previous valid count
`timescale 1ns/1ps
`default_nettype none
module s5a_top (
   input wire logic i_core_clk, // master clock, sets every rate
   input wire logic i_arst_n, // async reset, active low
   input wire logic i_mod_bit, // modulator output bit
   input wire logic [7:0] i_output_rate_code_bits, // output rate code
   output logic [s5a_pkg::RES_W-1:0] o_result, // signed averaged result
   output logic o_result_valid, // one-cycle pulse per result
   output logic [s5a_pkg::SINC_W-1:0] o_sinc5_data, // first-stage output
   output logic o_sinc5_valid, // one-cycle pulse per first-stage word
   output logic [s5a_pkg::CNT_W-1:0] o_num_ave, // count of current block
   output logic o_rate_code_bad // code on the input is unsupported
);
   // modulator phase
   logic [1:0] phase; // position within the four-clock sample slot
   logic mod_stb; // sample the modulator bit now

   // rate decode
   logic [s5a_pkg::NUM_RATES-1:0] hit; // one-hot table match
   logic [s5a_pkg::CNT_W-1:0] masked [s5a_pkg::NUM_RATES]; // per-entry count or zero
   logic [s5a_pkg::CNT_W-1:0] match_avg; // count for the current code
   logic code_ok; // current code is in the table
   logic [s5a_pkg::CNT_W-1:0] pending_avg; // last valid count, waits for block edge

   // averager
   logic [s5a_pkg::CNT_W-1:0] active_avg; // count of the block being summed
   logic [s5a_pkg::CNT_W-1:0] blk_cnt; // outputs already in the block
   logic [s5a_pkg::ACC_W-1:0] acc; // signed block sum
   logic [s5a_pkg::ACC_W-1:0] sinc_ext; // sign-extended first-stage word
   logic [s5a_pkg::ACC_W-1:0] sum_now; // sum including this word
   logic block_done; // this word closes the block

   // hand-off to the divider
   logic div_start; // pulse into the divider
   logic [s5a_pkg::ACC_W-1:0] div_dividend; // magnitude of the block sum
   logic [s5a_pkg::CNT_W-1:0] div_divisor; // count of that block
   logic div_neg; // block sum was negative
   logic [s5a_pkg::ACC_W-1:0] quotient; // divider answer
   logic div_done; // divider answer valid
   logic div_busy; // divider working
   s5a_pkg::s5a_state_e state; // result hand-off state

   // helper for checks
   logic [s5a_pkg::CNT_W-1:0] outs_seen; // first-stage words since last block end

   // four-clock sample slot; the modulator runs at the clock over four
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         phase <= s5a_pkg::PHASE_RESET;
      end else begin
         phase <= phase + 2'h1; // R2 R9
      end
   end

   assign mod_stb = (phase == s5a_pkg::PHASE_LAST); // R2

   // fixed first stage
   s5a_sinc5 u_sinc5 (
      .i_core_clk(i_core_clk),
      .i_arst_n(i_arst_n),
      .i_sample_stb(mod_stb),
      .i_mod_bit(i_mod_bit),
      .o_data(o_sinc5_data),
      .o_valid(o_sinc5_valid)
   );

   // compare the code against each table entry
   for (genvar i = 0; i < s5a_pkg::NUM_RATES; i++) begin : g_rate
      assign hit[i] = (i_output_rate_code_bits == s5a_pkg::RATE_CODE[i]); // R4
      assign masked[i] = hit[i] ? s5a_pkg::RATE_AVG[i] : '0; // R6 R7 R8
   end

   // merge the entries; at most one can match
   always_comb begin
      match_avg = '0;
      for (int j = 0; j < s5a_pkg::NUM_RATES; j++) begin
         match_avg = match_avg | masked[j];
      end
   end

   assign code_ok = |hit;

   // latch only supported codes, so a bad code never yields a zero count
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pending_avg <= s5a_pkg::AVG_RESET;
         o_rate_code_bad <= 1'b0;
      end else begin
         o_rate_code_bad <= !code_ok; // R15
         if (code_ok) begin
            pending_avg <= match_avg; // R4
         end
      end
   end

   // block accounting
   assign sinc_ext = {{(s5a_pkg::ACC_W-s5a_pkg::SINC_W){o_sinc5_data[s5a_pkg::SINC_W-1]}},
                      o_sinc5_data};
   assign sum_now = acc + sinc_ext; // R14 R10
   assign block_done = o_sinc5_valid && ((blk_cnt + s5a_pkg::AVG_ONE) == active_avg); // R5

   // accumulate; a new count takes effect only at a block edge so no block
   // is ever cut short or stretched by a rate change
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         acc <= '0;
         blk_cnt <= s5a_pkg::CNT_RESET;
         active_avg <= s5a_pkg::AVG_RESET;
      end else if (block_done) begin
         acc <= '0; // R14
         blk_cnt <= s5a_pkg::CNT_RESET;
         active_avg <= pending_avg; // R12
      end else if (o_sinc5_valid) begin
         acc <= sum_now; // R14 R11
         blk_cnt <= blk_cnt + s5a_pkg::AVG_ONE;
      end
   end

   assign o_num_ave = active_avg;

   // capture the closed block for the divider, as sign and magnitude
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         div_start <= 1'b0;
         div_dividend <= '0;
         div_divisor <= s5a_pkg::AVG_ONE;
         div_neg <= 1'b0;
      end else begin
         div_start <= block_done;
         if (block_done) begin
            div_neg <= sum_now[s5a_pkg::ACC_W-1];
            div_dividend <= sum_now[s5a_pkg::ACC_W-1] ? (~sum_now + 1'b1) : sum_now; // R14
            div_divisor <= active_avg; // R5
         end
      end
   end

   // division by the count; bypass still goes through it, dividing by one,
   // which keeps the latency the same for every rate
   s5a_divider u_divider (
      .i_core_clk(i_core_clk),
      .i_arst_n(i_arst_n),
      .i_start(div_start),
      .i_dividend(div_dividend),
      .i_divisor(div_divisor),
      .o_quotient(quotient),
      .o_done(div_done),
      .o_busy(div_busy)
   );

   // result hand-off; the next block ends 256 clocks later at the earliest,
   // so the divider is always free when a block closes
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state <= s5a_pkg::S5A_IDLE;
         o_result <= '0;
         o_result_valid <= 1'b0;
      end else begin
         o_result_valid <= 1'b0;
         case (state)
            s5a_pkg::S5A_IDLE: begin
               if (div_start) begin
                  state <= s5a_pkg::S5A_DIVIDE;
               end
            end
            s5a_pkg::S5A_DIVIDE: begin
               if (div_done) begin
                  // quotient is at most 2^30, so the low bits hold it whole
                  o_result <= div_neg ? s5a_pkg::RES_W'(~quotient + 1'b1)
                                      : quotient[s5a_pkg::RES_W-1:0]; // R5
                  o_result_valid <= 1'b1; // R5
                  state <= s5a_pkg::S5A_EMIT;
               end
            end
            s5a_pkg::S5A_EMIT: begin
               state <= s5a_pkg::S5A_IDLE;
            end
            default: begin
               state <= s5a_pkg::S5A_IDLE;
            end
         endcase
      end
   end

   // helper: words counted independently of the block counter
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         outs_seen <= s5a_pkg::CNT_RESET;
      end else if (block_done) begin
         outs_seen <= s5a_pkg::CNT_RESET;
      end else if (o_sinc5_valid) begin
         outs_seen <= outs_seen + s5a_pkg::AVG_ONE;
      end
   end

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_arst_n);

   sequence s_block_end;
      block_done;
   endsequence

   sequence s_answer;
      ##49 o_result_valid;
   endsequence

   a_mod_strobe: assert property (mod_stb |=> !mod_stb [*3] ##1 mod_stb) // R2
      else $error("modulator sample slot is not four clocks");

   a_code_slowest: assert property (i_output_rate_code_bits == 8'h03 |=> pending_avg == 14'h2EE0) // R6
      else $error("code 03h does not select 12000");

   a_code_sixty: assert property (i_output_rate_code_bits == 8'h72 |=> pending_avg == 14'h01F4) // R7
      else $error("code 72h does not select 500");

   a_code_bypass: assert property (i_output_rate_code_bits == 8'hF0 |=> pending_avg == 14'h0001) // R8
      else $error("code F0h does not select bypass");

   a_bad_keeps: assert property (!code_ok |=> $stable(pending_avg) && o_rate_code_bad) // R15
      else $error("unsupported code changed the count");

   a_block_count: assert property (block_done |-> (outs_seen + s5a_pkg::AVG_ONE) == active_avg) // R14
      else $error("block closed with wrong number of words");

   a_acc_clear: assert property (block_done |=> acc == '0 && blk_cnt == s5a_pkg::CNT_RESET) // R14
      else $error("accumulator not cleared after block");

   a_result_time: assert property (s_block_end |-> s_answer) // R5
      else $error("result not delivered 49 cycles after block end");

   a_bypass_pass: assert property (s_block_end and (active_avg == s5a_pkg::AVG_ONE)
      |-> ##49 (o_result_valid && o_result == $past(o_sinc5_data, 49))) // R8
      else $error("bypass result differs from first-stage word");
endmodule : s5a_top
`default_nettype wire

// ===== s5a_mod_model.sv
// modulator stand-in: one density-pattern bit per four master clocks
`timescale 1ns/1ps
`default_nettype none
module s5a_mod_model (
   input wire logic i_core_clk, // master clock
   input wire logic i_arst_n, // async reset, active low
   input wire logic [3:0] i_pattern, // stream bit k is i_pattern[k mod 4]
   output logic o_mod_bit // modulator bit toward the filter
);
   logic [1:0] phase; // clock count inside one sample period
   logic [1:0] idx; // position within the repeating pattern

   // phase follows the filter's sampling grid from reset release
   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         phase <= 2'h0;
         idx <= 2'h0;
      end else begin
         phase <= phase + 2'h1;
         if (phase == 2'h3) begin
            idx <= idx + 2'h1; // sample taken, move to next bit
         end
      end
   end

   // true bit only in the cycle ending with a sample edge; the inverse
   // elsewhere, so a filter sampling off the grid gives wrong sums
   initial begin
      o_mod_bit = 1'b0;
      forever begin
         @(negedge i_core_clk);
         if (phase == 2'h3) begin
            o_mod_bit = i_pattern[idx];
         end else begin
            o_mod_bit = ~i_pattern[idx];
         end
      end
   end
endmodule : s5a_mod_model
`default_nettype wire

// ===== s5a_top_bench.sv
// self-checking bench for the two-stage decimating filter
`timescale 1ns/1ps
`default_nettype none
module s5a_top_bench;
   localparam int LIMIT = 32'h9C40; // 40000 cycles, well above the run
   logic core_clk = 1'b0; // master clock, 100 MHz
   logic arst_n = 1'b0; // async reset, active low
   logic [7:0] rate_code = 8'hF0; // output rate code
   logic [3:0] pattern = 4'hF; // modulator density pattern
   logic mod_bit; // model to filter
   logic [s5a_pkg::RES_W-1:0] result; // averaged result
   logic result_valid; // result pulse
   logic [s5a_pkg::SINC_W-1:0] sinc_data; // first-stage word
   logic sinc_valid; // first-stage pulse
   logic [s5a_pkg::CNT_W-1:0] num_ave; // count of current block
   logic code_bad; // unsupported code flag
   int error_cnt = 0; // mismatches
   int checks = 0; // comparisons made
   int cyc = 0; // posedge counter
   int last_sinc = 0; // cycle of latest first-stage pulse

   s5a_mod_model model (.i_core_clk(core_clk), .i_arst_n(arst_n), .i_pattern(pattern),
      .o_mod_bit(mod_bit));
   s5a_top dut (.i_core_clk(core_clk), .i_arst_n(arst_n), .i_mod_bit(mod_bit),
      .i_output_rate_code_bits(rate_code), .o_result(result), .o_result_valid(result_valid),
      .o_sinc5_data(sinc_data), .o_sinc5_valid(sinc_valid), .o_num_ave(num_ave),
      .o_rate_code_bad(code_bad));

   // clock made outside the filter
   always #5 core_clk = ~core_clk;

   // cycle count, pulse stamps and hang guard; sampled at posedge so the
   // negedge-driven scenarios read stable values
   always @(posedge core_clk) begin
      if (sinc_valid === 1'b1) last_sinc = cyc;
      cyc = cyc + 1;
      if (cyc >= LIMIT) begin
         error_cnt++;
         close_out();
      end
   end

   task automatic close_out();
      if (error_cnt == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out

   task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : cmp_val

   task automatic cmp_flag(input string what, input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %b, seen %b", what, exp, got);
      end
   endtask : cmp_flag

   // reset held 12 cycles with the given code and pattern
   task automatic do_reset(input logic [7:0] code, input logic [3:0] pat);
      @(negedge core_clk);
      arst_n = 1'b0;
      rate_code = code;
      pattern = pat;
      repeat (12) @(negedge core_clk);
      arst_n = 1'b1;
   endtask : do_reset

   // bounded wait for the next first-stage pulse
   task automatic wait_sinc();
      int n = 0;
      @(negedge core_clk);
      while (sinc_valid !== 1'b1 && n < 300) begin
         @(negedge core_clk);
         n++;
      end
      cmp_flag("sinc5 pulse", 1'b1, sinc_valid);
   endtask : wait_sinc

   // bounded wait for the next result pulse
   task automatic wait_res(input int lim);
      int n = 0;
      @(negedge core_clk);
      while (result_valid !== 1'b1 && n < lim) begin
         @(negedge core_clk);
         n++;
      end
      cmp_flag("result pulse", 1'b1, result_valid);
   endtask : wait_res

   task automatic t_reset();
      do_reset(8'h03, 4'hF);
      @(negedge core_clk);
      cmp_val("count after reset", 32'h1, {18'h0, num_ave});
      cmp_val("result after reset", 32'h0, result);
      cmp_flag("result pulse", 1'b0, result_valid);
      cmp_flag("sinc5 pulse", 1'b0, sinc_valid);
   endtask : t_reset

   // bypass: word gain, spacing, latency, sign for three densities
   task automatic t_bypass();
      logic [31:0] exp [3] = '{32'h40000000, 32'hC0000000, 32'hE0000000};
      logic [3:0] pat [3] = '{4'hF, 4'h0, 4'h1};
      int t0;
      do_reset(8'hF0, 4'hF);
      for (int i = 0; i < 3; i++) begin
         pattern = pat[i];
         repeat (8) wait_sinc();
         t0 = cyc;
         wait_sinc();
         cmp_val("sinc5 spacing", 32'h100, cyc - t0);
         cmp_val("sinc5 word", exp[i], sinc_data);
         wait_res(60);
         cmp_val("result latency", 32'h31, cyc - last_sinc);
         cmp_val("bypass result", exp[i], result);
      end
   endtask : t_bypass

   // every valid code reaches its count at the first block close
   task automatic t_codes();
      logic [7:0] code [16] = '{8'h03, 8'h13, 8'h23, 8'h33, 8'h43, 8'h53, 8'h63, 8'h72,
         8'h82, 8'h92, 8'hA1, 8'hB0, 8'hC0, 8'hD0, 8'hE0, 8'hF0};
      logic [31:0] cnt [16] = '{32'h2EE0, 32'h1770, 32'hBB8, 32'h7D0, 32'h4B0, 32'h3E8,
         32'h258, 32'h1F4, 32'h12C, 32'h3C, 32'h1E, 32'hF, 32'h8, 32'h4, 32'h2, 32'h1};
      for (int i = 0; i < 16; i++) begin
         do_reset(code[i], 4'hF);
         wait_sinc();
         @(negedge core_clk);
         cmp_val("average count", cnt[i], {18'h0, num_ave});
         cmp_flag("unsupported flag", 1'b0, code_bad);
      end
   endtask : t_codes

   // averaging by 2 then by 8 after a change taken at a block boundary
   task automatic t_average();
      int t0;
      do_reset(8'hE0, 4'h7);
      repeat (10) wait_sinc();
      wait_res(600);
      t0 = cyc;
      wait_res(600);
      cmp_val("result spacing", 32'h200, cyc - t0);
      cmp_val("result latency", 32'h31, cyc - last_sinc);
      cmp_val("average result", 32'h20000000, result);
      rate_code = 8'hC0;
      wait_res(600);
      wait_res(2100);
      t0 = cyc;
      wait_res(2100);
      cmp_val("result spacing", 32'h800, cyc - t0);
      cmp_val("average count", 32'h8, {18'h0, num_ave});
      cmp_val("average result", 32'h20000000, result);
   endtask : t_average

   // unsupported codes are flagged and leave the count alone
   task automatic t_bad_code();
      logic [7:0] bad [3] = '{8'h00, 8'hF1, 8'hFF};
      do_reset(8'hE0, 4'hF);
      wait_sinc();
      for (int i = 0; i < 3; i++) begin
         rate_code = bad[i];
         @(negedge core_clk);
         cmp_flag("unsupported flag", 1'b1, code_bad);
         repeat (3) wait_sinc();
         @(negedge core_clk);
         cmp_val("kept count", 32'h2, {18'h0, num_ave});
      end
      rate_code = 8'hE0;
      @(negedge core_clk);
      cmp_flag("unsupported flag", 1'b0, code_bad);
   endtask : t_bad_code

   initial begin
      t_reset();
      t_bypass();
      t_codes();
      t_average();
      t_bad_code();
      close_out();
   end
endmodule : s5a_top_bench
`default_nettype wire
